/* File: shared/iso_rx_filter_if.sv */
`timescale 1ns/1ps
interface iso_rx_filter_if;
   logic [31:0] match;
   logic [1:0]  tag;
   logic [3:0]  sync;
   logic [5:0]  channel;
   logic        wait_sync;
   logic        tag_ok;
   logic        chan_ok;
   logic        sync_ok;

   modport ctl (output match, tag, sync, channel, wait_sync,
                input  tag_ok, chan_ok, sync_ok);
   modport flt (input  match, tag, sync, channel, wait_sync,
                output tag_ok, chan_ok, sync_ok);
endinterface

/* File: shared/iso_rx_match_defs.svh */
`ifndef ISO_RX_MATCH_DEFS_SVH
`define ISO_RX_MATCH_DEFS_SVH

`define RX_CMD_PTR_BASE   16'h040c
`define RX_MATCH_BASE     16'h410c
`define RX_CTX_STRIDE_LG2 5
`define RX_NUM_CTX        4
`define RX_CTX_IDX_W      2

`define MATCH_WR_MASK     32'hf7ffff7f
`define MATCH_RESET       32'h00000000
`define PTR_RESET         32'h00000000

`define ACCEPT_TAG_THREE_EN_BIT 31
`define ACCEPT_TAG_TWO_EN_BIT   30
`define ACCEPT_TAG_ONE_EN_BIT   29
`define ACCEPT_TAG_ZERO_EN_BIT  28
`define MATCH_CYC_MSB     26
`define MATCH_CYC_LSB     12
`define MATCH_SYNC_MSB    11
`define MATCH_SYNC_LSB    8
`define MATCH_GATE_BIT    6
`define MATCH_CHAN_MSB    5
`define MATCH_CHAN_LSB    0

`define TAG_VAL_ZERO      2'b00
`define TAG_VAL_ONE       2'b01
`define TAG_VAL_TWO       2'b10
`define TAG_VAL_THREE     2'b11
`define GATE_SYNC_TOP     2'b00
`define SYNC_TOP_MSB      3
`define SYNC_TOP_LSB      2
`define TIMER_SEC_LOW_MSB 1

`endif

/* File: shared/iso_rx_match_pkg.sv */
package iso_rx_match_pkg;

   // Per-context start sequencing
   typedef enum logic [1:0] {
      CTX_STOPPED,
      CTX_HOLD,
      CTX_OPEN
   } ctx_state_t;

   typedef enum logic [1:0] {
      REG_NONE,
      REG_CMD_PTR,
      REG_MATCH
   } reg_kind_t;

endpackage

/* File: test/iso_rx_context_match_filter_chk.sv */
`timescale 1ns/1ps
module iso_rx_context_match_filter_chk #(
   parameter int NUM_CTX = 4
) (
   input wire logic               i_clk,
   input wire logic               i_rst,
   input wire logic               i_reg_wr,
   input wire logic               i_reg_rd,
   input wire logic [15:0]        i_reg_addr,
   input wire logic [31:0]        i_reg_wdata,
   input wire logic [31:0]        o_reg_rdata,
   input wire logic               o_reg_ack,
   input wire logic [NUM_CTX-1:0] i_run,
   input wire logic [NUM_CTX-1:0] i_start_on_cycle_en,
   input wire logic [NUM_CTX-1:0] i_multi_channel_receive,
   input wire logic [NUM_CTX-1:0] o_fetch_req,
   input wire logic [6:0]         i_timer_seconds_field,
   input wire logic [12:0]        i_timer_cycle_field,
   input wire logic [5:0]         i_pkt_channel,
   input wire logic [1:0]         i_pkt_tag,
   input wire logic [NUM_CTX-1:0] o_pkt_accept,
   input wire logic [NUM_CTX-1:0] o_ctx_waiting
);
   logic [NUM_CTX-1:0] run_q;
   logic [31:0]        m0_q;
   logic               cyc_eq;
   assign cyc_eq = {i_timer_seconds_field[1:0], i_timer_cycle_field} == m0_q[26:12];
   // Cleared with the design's copy so no false rise follows a reset
   always_ff @(posedge i_clk)
      if (i_rst) run_q <= '0;
      else run_q <= i_run;
   // Only context 0 is shadowed, to keep the checker small
   always_ff @(posedge i_clk)
      if (i_rst) m0_q <= '0;
      else if (i_reg_wr && i_reg_addr == 16'h410c) m0_q <= i_reg_wdata;
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   sequence s_hold_start;
      i_run[0] && !run_q[0] && i_start_on_cycle_en[0] && !cyc_eq;
   endsequence
   sequence s_hold_met;
      o_ctx_waiting[0] && i_run[0] && cyc_eq;
   endsequence
   a_ack_follows: assert property ((i_reg_wr || i_reg_rd) |=> o_reg_ack)
      else $error("ack missing");
   a_rsvd_zero: assert property (i_reg_rd && i_reg_addr[15:8] == 8'h41
      |=> !o_reg_rdata[27] && !o_reg_rdata[7]) else $error("reserved bit set");
   a_fetch_rise: assert property (##1 o_fetch_req == $past(i_run & ~run_q))
      else $error("bad fetch pulse");
   a_chan_match: assert property (o_pkt_accept[0] |-> $past(i_pkt_channel) == $past(m0_q[5:0]))
      else $error("wrong channel");
   a_tag_enabled: assert property (o_pkt_accept[0] |-> $past(m0_q[5'd28 + i_pkt_tag]))
      else $error("tag not enabled");
   a_multi_block: assert property ((o_pkt_accept & $past(i_multi_channel_receive)) == '0)
      else $error("multi accepted");
   a_hold_start: assert property (s_hold_start |-> ##[1:2] o_ctx_waiting[0])
      else $error("no hold");
   a_hold_end: assert property (s_hold_met |-> ##[1:2] !o_ctx_waiting[0])
      else $error("hold stuck");
endmodule

bind iso_rx_context_match_filter iso_rx_context_match_filter_chk #(.NUM_CTX(NUM_CTX)) u_chk (.*);

/* File: test/iso_rx_context_match_filter_test.sv */
`timescale 1ns/1ps
module iso_rx_context_match_filter_test;
   logic        i_clk = 0, i_rst = 1, i_reg_wr = 0, i_reg_rd = 0, i_ptr_load = 0;
   logic        i_pkt_valid, o_reg_ack;
   logic [1:0]  i_ptr_ctx = 0, i_pkt_tag;
   logic [3:0]  i_run = 0, i_start_on_cycle_en = 0, i_multi_channel_receive = 0, i_wait_sync = 0;
   logic [3:0]  i_pkt_sync, o_fetch_req, o_pkt_accept, o_ctx_waiting, e;
   logic [5:0]  i_pkt_channel;
   logic [6:0]  i_timer_seconds_field = 0;
   logic [12:0] i_timer_cycle_field = 0;
   logic [15:0] i_reg_addr = 0;
   logic [31:0] i_reg_wdata = 0, i_ptr_value = 0, o_reg_rdata, o_fetch_addr, q, m [4], p [4];
   int          seed = 8, err_count = 0, n_checks = 0;

   always #12.5 i_clk = ~i_clk;
   iso_rx_context_match_filter u_iso_rx_context_match_filter (.*);
   iso_rx_link_model u_iso_rx_link_model (.i_clk, .o_valid(i_pkt_valid), .o_channel(i_pkt_channel),
      .o_tag(i_pkt_tag), .o_sync(i_pkt_sync));

   task automatic step(int n = 1);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   task automatic check(string s, logic [31:0] got, logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         $display("unexpected %s: expected %h seen %h", s, exp, got);
         err_count++;
      end
   endtask
   task automatic acc(logic wr, logic [15:0] a, logic [31:0] d);
      {i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} = {wr, !wr, a, d};
      step();
      {i_reg_wr, i_reg_rd} = 2'b00;
      check("ack", 32'(o_reg_ack), 1);
      q = o_reg_rdata;
      step();
   endtask
   task automatic pkt(logic [11:0] h, logic [3:0] x);
      u_iso_rx_link_model.send(h);
      check("accept", 32'(o_pkt_accept), 32'(x));
      step();
   endtask
   function automatic logic exp_ok(logic [31:0] r, logic [11:0] h, logic w);
      return h[11:6] == r[5:0] && r[28 + h[5:4]] && !(r[6] && h[5:4] == 2'b01 && h[3:2] != 2'b00)
         && (!w || h[3:0] == r[11:8]);
   endfunction
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      logic [11:0] h;
      logic [31:0] r;
      step(4);
      i_rst = 0;
      for (int n = 0; n < 4; n++) begin
         {p[n], m[n]} = {$random(seed), $random(seed)};
         {i_ptr_ctx, i_ptr_value, i_ptr_load} = {2'(n), p[n], 1'b1};
         step();
         i_ptr_load = 0;
         acc(1, 16'h040c + 16'(n * 32), ~p[n]);
         acc(0, 16'h040c + 16'(n * 32), 0);
         check("pointer", q, p[n]);
         acc(1, 16'h410c + 16'(n * 32), m[n]);
         acc(0, 16'h410c + 16'(n * 32), 0);
         check("match", q, m[n] & 32'hf7ffff7f);
      end
      acc(0, 16'h0410, 0);
      check("unmapped", q, 0);
      $display("registers done");
      for (int n = 0; n < 4; n++) begin
         i_run[n] = 1;
         step();
         check("fetch", 32'(o_fetch_req), 32'(1 << n));
         check("fetch_addr", o_fetch_addr, p[n]);
      end
      i_run = 0;
      step();
      i_run = 4'hf;
      step();
      check("fetch", 32'(o_fetch_req), 32'hf);
      check("fetch_addr", o_fetch_addr, p[0]);
      $display("fetch done");
      for (int k = 0; k < 400; k++) begin
         r = $random(seed);
         h = r[11:0];
         if (r[12]) h[11:6] = m[r[14:13]][5:0];
         if (r[15]) h[3:0] = r[16] ? m[r[14:13]][11:8] : {2'b00, r[18:17]};
         i_multi_channel_receive = r[23:20] & r[27:24];
         i_wait_sync = r[31:28];
         for (int n = 0; n < 4; n++) e[n] = !i_multi_channel_receive[n] && exp_ok(m[n], h, i_wait_sync[n]);
         pkt(h, e);
      end
      $display("filter done");
      {i_run, i_multi_channel_receive, i_wait_sync, i_start_on_cycle_en} = 16'h0001;
      // Low seconds bits differ while the cycle count already matches
      {i_timer_seconds_field, i_timer_cycle_field} = {7'h7e, 13'h1abc};
      acc(1, 16'h410c, {4'h1, 1'b0, 2'b01, 13'h1abc, 12'h005});
      i_run[0] = 1;
      step(3);
      check("waiting", 32'(o_ctx_waiting), 1);
      pkt(12'h140, 0);
      i_timer_seconds_field = 7'h05;
      for (int w = 0; w < 4 && o_ctx_waiting[0] !== 1'b0; w++) step();
      check("waiting", 32'(o_ctx_waiting), 0);
      pkt(12'h140, 4'h1);
      $display("cycle start done");
      // Hold once more, then reset in mid-run
      i_run[0] = 0;
      i_timer_seconds_field = 7'h7e;
      step();
      i_run[0] = 1;
      step(3);
      check("waiting", 32'(o_ctx_waiting), 1);
      {i_rst, i_run} = {1'b1, 4'h0};
      step();
      check("waiting", 32'(o_ctx_waiting), 0);
      step();
      i_rst = 0;
      acc(0, 16'h410c, 0);
      check("match", q, 0);
      // Match now zero so the timer misses; a dropped enable releases
      i_run[0] = 1;
      step(3);
      check("waiting", 32'(o_ctx_waiting), 1);
      i_start_on_cycle_en[0] = 0;
      step(2);
      check("waiting", 32'(o_ctx_waiting), 0);
      $display("reset done");
      stop_test();
   end
endmodule

/* File: test/iso_rx_link_model.sv */
`timescale 1ns/1ps
module iso_rx_link_model (
   input  wire logic  i_clk,
   output logic       o_valid,
   output logic [5:0] o_channel,
   output logic [1:0] o_tag,
   output logic [3:0] o_sync
);
   initial {o_valid, o_channel, o_tag, o_sync} = '0;
   // Fields flip after the header so stale values never pass
   task automatic send(input logic [11:0] h);
      {o_channel, o_tag, o_sync} = h;
      o_valid = 1;
      @(posedge i_clk) #1;
      o_valid = 0;
      {o_channel, o_tag, o_sync} = ~h;
   endtask
endmodule

/* File: verilog/iso_rx_context_match_filter.sv */
`timescale 1ns/1ps
`include "iso_rx_match_defs.svh"
// Overview of operation
// [RULE_01] Keep first descriptor address; fetch on run
// [RULE_02] Four contexts, registers at 32-byte stride
// [RULE_03] Bits 31-28 enable tags 11b..00b
// [RULE_04] Reserved match bits 27, 7 read zero
// [RULE_05] Cycle field: two seconds bits, cycle count
// [RULE_06] Hold reception until timer equals cycle value
// [RULE_07] Compare sync field while wait is 11b
// [RULE_08] Sync gate: tag 01b needs sync top 00b
// [RULE_09] Other tags accepted by enables only
// [RULE_10] Six-bit channel selects accepted channel
// [RULE_11] Software alone sets and clears run
// [RULE_12] Multi-channel off: single programmed channel only
// [RULE_13] Accept needs channel, tag, and start met
module iso_rx_context_match_filter
   import iso_rx_match_pkg::*;
#(
   parameter int NUM_CTX = `RX_NUM_CTX
) (
   input  wire logic                     i_clk,
   input  wire logic                     i_rst,
   // Register port
   input  wire logic                     i_reg_wr,
   input  wire logic                     i_reg_rd,
   input  wire logic [15:0]              i_reg_addr,
   input  wire logic [31:0]              i_reg_wdata,
   output logic      [31:0]              o_reg_rdata,
   output logic                          o_reg_ack,
   // Context control and descriptor engine
   input  wire logic [NUM_CTX-1:0]       i_run,
   input  wire logic [NUM_CTX-1:0]       i_start_on_cycle_en,
   input  wire logic [NUM_CTX-1:0]       i_multi_channel_receive,
   input  wire logic [NUM_CTX-1:0]       i_wait_sync,
   input  wire logic                     i_ptr_load,
   input  wire logic [1:0]               i_ptr_ctx,
   input  wire logic [31:0]              i_ptr_value,
   output logic      [NUM_CTX-1:0]       o_fetch_req,
   output logic      [31:0]              o_fetch_addr,
   // Cycle timer
   input  wire logic [6:0]               i_timer_seconds_field,
   input  wire logic [12:0]              i_timer_cycle_field,
   // Receive path
   input  wire logic                     i_pkt_valid,
   input  wire logic [5:0]               i_pkt_channel,
   input  wire logic [1:0]               i_pkt_tag,
   input  wire logic [3:0]               i_pkt_sync,
   output logic      [NUM_CTX-1:0]       o_pkt_accept,
   output logic      [NUM_CTX-1:0]       o_ctx_waiting
);

   logic [31:0]      cmd_ptr_q   [NUM_CTX];
   logic [31:0]      match_q     [NUM_CTX];
   ctx_state_t       state_q     [NUM_CTX];
   logic [NUM_CTX-1:0] run_q;
   logic [NUM_CTX-1:0] run_rise;
   logic [NUM_CTX-1:0] cyc_hit;
   logic [NUM_CTX-1:0] filt_ok;
   logic [14:0]      timer_now;
   reg_kind_t        acc_kind;
   logic [1:0]       acc_ctx;
   logic [31:0]      rdata_d;
   logic [31:0]      fetch_addr_d;

   // [RULE_05] Two low seconds bits then cycle count
   assign timer_now = {i_timer_seconds_field[`TIMER_SEC_LOW_MSB:0], i_timer_cycle_field};

   // [RULE_02] Context index from 32-byte stride
   function automatic logic [2:0] ctx_of(input logic [15:0] addr, input logic [15:0] base);
      logic [15:0] off;
      off = addr - base;
      if ((addr >= base) && (off[`RX_CTX_STRIDE_LG2-1:0] == '0) &&
          ((off >> `RX_CTX_STRIDE_LG2) < 16'(NUM_CTX))) begin
         ctx_of = {1'b1, off[`RX_CTX_STRIDE_LG2+1:`RX_CTX_STRIDE_LG2]};
      end else begin
         ctx_of = 3'h0;
      end
   endfunction

   always_comb begin
      logic [2:0] p;
      logic [2:0] m;
      p = ctx_of(i_reg_addr, `RX_CMD_PTR_BASE);
      m = ctx_of(i_reg_addr, `RX_MATCH_BASE);
      if (p[2]) begin
         acc_kind = REG_CMD_PTR;
         acc_ctx  = p[1:0];
      end else if (m[2]) begin
         acc_kind = REG_MATCH;
         acc_ctx  = m[1:0];
      end else begin
         acc_kind = REG_NONE;
         acc_ctx  = 2'h0;
      end
   end

   always_comb begin
      if (acc_kind == REG_CMD_PTR) begin
         rdata_d = cmd_ptr_q[acc_ctx];
      end else if (acc_kind == REG_MATCH) begin
         // [RULE_04] Reserved bits masked
         rdata_d = match_q[acc_ctx] & `MATCH_WR_MASK;
      end else begin
         rdata_d = 32'h00000000;
      end
   end

   // Read data and ack, one cycle after request
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_reg_rdata <= 32'h00000000;
         o_reg_ack   <= 1'b0;
      end else begin
         o_reg_ack   <= i_reg_wr || i_reg_rd;
         o_reg_rdata <= i_reg_rd ? rdata_d : 32'h00000000;
      end
   end

   // Match registers, software-written; reserved bits never stored
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         for (int i = 0; i < NUM_CTX; i++) begin
            match_q[i] <= `MATCH_RESET;
         end
      end else if (i_reg_wr && (acc_kind == REG_MATCH)) begin
         // [RULE_03] Tag enables stored freely
         match_q[acc_ctx] <= i_reg_wdata & `MATCH_WR_MASK;
      end
   end

   // Pointer is read-only to software; descriptor engine loads it
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         for (int i = 0; i < NUM_CTX; i++) begin
            cmd_ptr_q[i] <= `PTR_RESET;
         end
      end else if (i_ptr_load) begin
         // [RULE_01] Keep first block address
         cmd_ptr_q[i_ptr_ctx] <= i_ptr_value;
      end
   end

   // [RULE_11] Run is only observed, never driven here
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         run_q <= '0;
      end else begin
         run_q <= i_run;
      end
   end
   assign run_rise = i_run & ~run_q;

   always_comb begin
      fetch_addr_d = o_fetch_addr;
      // Lowest context wins when several start together
      for (int i = NUM_CTX - 1; i >= 0; i--) begin
         if (run_rise[i]) begin
            fetch_addr_d = cmd_ptr_q[i];
         end
      end
   end

   // [RULE_01] Fetch request on run set
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_fetch_req  <= '0;
         o_fetch_addr <= `PTR_RESET;
      end else begin
         o_fetch_req  <= run_rise;
         o_fetch_addr <= fetch_addr_d;
      end
   end

   // [RULE_06] Timer compare against start value
   always_comb begin
      for (int i = 0; i < NUM_CTX; i++) begin
         cyc_hit[i] = (timer_now == match_q[i][`MATCH_CYC_MSB:`MATCH_CYC_LSB]);
      end
   end

   // Start sequencing per context
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         for (int i = 0; i < NUM_CTX; i++) begin
            state_q[i] <= CTX_STOPPED;
         end
      end else begin
         for (int i = 0; i < NUM_CTX; i++) begin
            if (!i_run[i]) begin
               state_q[i] <= CTX_STOPPED;
            end else begin
               case (state_q[i])
                  CTX_STOPPED: begin
                     // [RULE_06] Hold off until cycle match
                     if (i_start_on_cycle_en[i] && !cyc_hit[i]) begin
                        state_q[i] <= CTX_HOLD;
                     end else begin
                        state_q[i] <= CTX_OPEN;
                     end
                  end
                  CTX_HOLD: begin
                     if (cyc_hit[i] || !i_start_on_cycle_en[i]) begin
                        state_q[i] <= CTX_OPEN;
                     end
                  end
                  CTX_OPEN: state_q[i] <= CTX_OPEN;
                  default:  state_q[i] <= CTX_STOPPED;
               endcase
            end
         end
      end
   end

   // One filter slice per context
   for (genvar g = 0; g < NUM_CTX; g++) begin : g_ctx
      iso_rx_filter_if fif ();
      assign fif.match     = match_q[g];
      assign fif.tag       = i_pkt_tag;
      assign fif.sync      = i_pkt_sync;
      assign fif.channel   = i_pkt_channel;
      assign fif.wait_sync = i_wait_sync[g];
      // [RULE_12] Single channel only without multi-channel
      assign filt_ok[g]    = fif.tag_ok && fif.chan_ok && fif.sync_ok && !i_multi_channel_receive[g];

      iso_rx_packet_filter u_filter (
         .f (fif.flt)
      );
   end

   // [RULE_13] Accept when all conditions met
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_pkt_accept <= '0;
      end else begin
         for (int i = 0; i < NUM_CTX; i++) begin
            o_pkt_accept[i] <= i_pkt_valid && filt_ok[i] && (state_q[i] == CTX_OPEN);
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_ctx_waiting <= '0;
      end else begin
         for (int i = 0; i < NUM_CTX; i++) begin
            o_ctx_waiting[i] <= (state_q[i] == CTX_HOLD);
         end
      end
   end

endmodule

/* File: verilog/iso_rx_packet_filter.sv */
`timescale 1ns/1ps
`include "iso_rx_match_defs.svh"
module iso_rx_packet_filter
   import iso_rx_match_pkg::*;
(
   iso_rx_filter_if.flt f
);
   logic tag_en;
   logic gate_blocks;

   always_comb begin
      // [RULE_03] Tag enable select
      case (f.tag)
         `TAG_VAL_THREE: tag_en = f.match[`ACCEPT_TAG_THREE_EN_BIT];
         `TAG_VAL_TWO:   tag_en = f.match[`ACCEPT_TAG_TWO_EN_BIT];
         `TAG_VAL_ONE:   tag_en = f.match[`ACCEPT_TAG_ONE_EN_BIT];
         default:        tag_en = f.match[`ACCEPT_TAG_ZERO_EN_BIT];
      endcase
   end

   // [RULE_08] Tag one sync gate
   // [RULE_09] Other tags unrestricted
   assign gate_blocks = f.match[`MATCH_GATE_BIT] && (f.tag == `TAG_VAL_ONE) &&
                        (f.sync[`SYNC_TOP_MSB:`SYNC_TOP_LSB] != `GATE_SYNC_TOP);
   assign f.tag_ok    = tag_en && !gate_blocks;

   // [RULE_10] Channel compare
   assign f.chan_ok   = (f.channel == f.match[`MATCH_CHAN_MSB:`MATCH_CHAN_LSB]);

   // [RULE_07] Sync compare on wait
   assign f.sync_ok   = !f.wait_sync || (f.sync == f.match[`MATCH_SYNC_MSB:`MATCH_SYNC_LSB]);
endmodule
